// ---- logic/drc_core.sv ----
// How it works
// - Make-up gain code n gives +n dB up to 12; codes 13 and up reserved
// - Timing bit 7 enables the stage; cleared means bypass; resets to zero
// - Compression ratio codes 0..4 give 1:1, 1.5:1, 2:1, 4:1, infinite:1
// - Compression threshold code n means minus n dB
// - Below the expansion threshold gain stays reduced until level recovers
// - Expansion ratio 1:1, 1:2 or 1:3; threshold -35 to -66 dB
// - Entering compression moves gain at the attack rate
// - Leaving compression restores gain at the release rate
// - Entering expansion applies the ratio at the release rate
// - Leaving expansion restores gain at the attack rate
// - Settings are dB-per-time rates calibrated for a 12 dB overshoot
// - Release duration follows how far gain had been pulled down
// - Entering expansion waits a release-scaled delay; exit has none
// - Release code 0..7 selects 8 s down to 0.0625 s
// - Attack code 0..7 selects 0.125 ms up to 50 ms
// - Above the compression threshold gain drops by the chosen ratio
// - Meant for use with the linear-phase music filter mode
module drc_core
   import drc_pkg::*;
#(
   parameter int SAMPLE_RATE_HZ = DRC_SAMPLE_RATE
)(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [DRC_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  fir_music_mode,
   input  wire logic                  in_valid,
   input  wire drc_frame_t            in_frame,
   output logic                       out_valid,
   output drc_frame_t                 out_frame
);

   // dB level of the larger channel magnitude, 0 = full scale
   function automatic logic signed [9:0] level_db(input drc_frame_t f);
      logic [23:0] ml;
      logic [23:0] mr;
      logic [23:0] m;
      int          p;
      logic [1:0]  mant;
      int          db;
      ml = f.left[23] ? 24'(-f.left) : f.left;
      mr = f.right[23] ? 24'(-f.right) : f.right;
      m = (ml > mr) ? ml : mr;
      p = -1;
      mant = 2'h0;
      for (int i = 0; i < 24; i++) begin
         if (m[i]) begin
            p = i;
         end
      end
      if (p < 0) begin
         db = DRC_SILENCE_DB;
      end else begin
         mant = (p >= 2) ? 2'(m >> (p - 2)) : 2'h0;
         db = -6 * (23 - p) + 6 - int'(DRC_MANT_DB[mant]);
      end
      return 10'(db);
   endfunction

   // dB change per sample in 16-bit fraction
   function automatic logic [31:0] rate_step(input int unsigned t_us);
      longint unsigned num;
      longint unsigned den;
      longint unsigned q;
      num = longint'(DRC_REF_OVER_DB) * (longint'(1) << DRC_FRAC) * longint'(DRC_US_PER_S);
      den = longint'(t_us) * longint'(SAMPLE_RATE_HZ);
      q = num / den;
      return (q == 0) ? 32'h00000001 : 32'(q);
   endfunction

   // Gain reduction for a given overshoot and ratio code
   function automatic logic signed [11:0] comp_red(input logic signed [11:0] over,
                                                   input logic [2:0] code);
      logic signed [11:0] r;
      unique case (code)
         3'h1:    r = over / 12'sd3;
         3'h2:    r = over >>> 1;
         3'h3:    r = over - (over >>> 2);
         3'h4:    r = over;
         default: r = 12'sh000;
      endcase
      return r;
   endfunction

   // Apply an integer dB gain (max +12) to one sample with saturation
   function automatic logic signed [23:0] apply_gain(input logic signed [23:0] s,
                                                     input logic signed [11:0] g);
      int                 n;
      int                 q;
      logic signed [41:0] prod;
      logic signed [41:0] sh;
      n = int'(DRC_MAKEUP_MAX) - int'(g);
      q = n / 6;
      prod = 42'(s) * $signed({1'b0, DRC_DB_LUT[n % 6]});
      sh = prod >>> (13 + q);
      if (sh > 42'sh7FFFFF) begin
         return 24'sh7FFFFF;
      end else if (sh < -42'sh800000) begin
         return -24'sh800000;
      end
      return 24'(sh);
   endfunction

   // Register file: shadow copies written by software, active copy per sample
   logic [7:0] reg_timing;
   logic [7:0] reg_comp;
   logic [7:0] reg_expand;
   logic [7:0] reg_makeup;
   drc_cfg_t   act;
   logic [31:0] status;

   wire logic [7:0] idx      = paddr[9:2];
   wire logic       word_ok  = (paddr[1:0] == 2'h0) && (paddr[DRC_ADDR_W-1:10] == '0);
   wire logic       hit_tim  = word_ok && (idx == DRC_IDX_TIMING);
   wire logic       hit_cmp  = word_ok && (idx == DRC_IDX_COMP);
   wire logic       hit_exp  = word_ok && (idx == DRC_IDX_EXPAND);
   wire logic       hit_mkg  = word_ok && (idx == DRC_IDX_MAKEUP);
   wire logic       hit_st   = word_ok && (idx == DRC_IDX_STATUS);
   wire logic       hit      = hit_tim | hit_cmp | hit_exp | hit_mkg | hit_st;
   wire logic       acc      = psel & penable;
   wire logic       wr       = acc & pwrite & hit;

   assign pready  = 1'b1;
   assign pslverr = acc & ~hit;
   assign prdata  = hit_tim ? {24'h0, reg_timing & 8'hF7} :
                    hit_cmp ? {24'h0, reg_comp} :
                    hit_exp ? {24'h0, reg_expand} :
                    hit_mkg ? {24'h0, reg_makeup & 8'h1F} :
                    hit_st  ? status : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_timing <= DRC_RST_TIMING;
         reg_comp   <= DRC_RST_COMP;
         reg_expand <= DRC_RST_EXPAND;
         reg_makeup <= DRC_RST_MAKEUP;
      end else if (wr) begin
         if (hit_tim) reg_timing <= pwdata[7:0];
         if (hit_cmp) reg_comp   <= pwdata[7:0];
         if (hit_exp) reg_expand <= pwdata[7:0];
         if (hit_mkg) reg_makeup <= pwdata[7:0];
      end
   end

   wire drc_cfg_t shadow = '{en:  reg_timing[DRC_EN_BIT],
                             rel: reg_timing[DRC_REL_LSB +: 3],
                             atk: reg_timing[DRC_ATK_LSB +: 3],
                             cmp: reg_comp[DRC_CMP_LSB +: 3],
                             thc: reg_comp[DRC_THC_LSB +: 5],
                             exr: reg_expand[DRC_EXR_LSB +: 3],
                             the: reg_expand[DRC_THE_LSB +: 5],
                             mkg: reg_makeup[DRC_MKG_LSB +: 5]};

   // settings latch only on a sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act <= '0;
      end else if (in_valid) begin
         act <= shadow;
      end
   end

   // Level analysis against both thresholds
   logic signed [31:0] gain_fix;
   logic signed [31:0] delay_acc;
   logic signed [31:0] delay_goal;
   logic               exp_zone_q;
   logic               exp_was;

   wire logic signed [11:0] lvl       = 12'(level_db(in_frame));
   // threshold code n is -n dB
   wire logic signed [11:0] comp_over = lvl + $signed({7'h0, act.thc});
   wire logic               comp_on   = (act.cmp >= 3'h1) && (act.cmp <= 3'h4);
   wire logic               comp_zone = comp_on && (comp_over > 12'sh000);
   wire logic signed [11:0] red_c     = comp_zone ? comp_red(comp_over, act.cmp) : 12'sh000;
   wire logic signed [11:0] exp_thr   = -12'(DRC_EXP_THR_BASE) - $signed({7'h0, act.the});
   wire logic signed [11:0] under     = exp_thr - lvl;
   wire logic               exp_on    = (act.exr == 3'h1) || (act.exr == 3'h2);
   wire logic               exp_zone  = exp_on && (under > 12'sh000);
   wire logic               exp_entry = exp_zone & ~exp_zone_q;
   // hold off expansion until the delay expires
   wire logic               exp_wait  = exp_zone && (exp_entry || (delay_acc < delay_goal));
   wire logic signed [11:0] red_e     = (exp_zone && !exp_wait) ?
                                        ((act.exr == 3'h2) ? (under <<< 1) : under) : 12'sh000;
   // reserved make-up codes give 0 dB
   wire logic signed [11:0] makeup    = (act.mkg <= DRC_MAKEUP_MAX) ?
                                        $signed({7'h0, act.mkg}) : 12'sh000;
   wire logic signed [11:0] tgt_raw   = makeup - red_c - red_e;
   wire logic signed [11:0] tgt_db    = (tgt_raw < 12'(DRC_GAIN_FLOOR)) ?
                                        12'(DRC_GAIN_FLOOR) : tgt_raw;
   wire logic signed [31:0] tgt_fix   = 32'(tgt_db) <<< DRC_FRAC;

   wire logic [31:0] rel_step = rate_step(DRC_RELEASE_US[act.rel]);
   wire logic [31:0] atk_step = rate_step(DRC_ATTACK_US[act.atk]);

   // up out of compression uses release
   // up out of expansion uses attack
   wire logic        going_down = tgt_fix < gain_fix;
   wire logic [31:0] step       = going_down ? (exp_zone ? rel_step : atk_step) :
                                  ((exp_was && !comp_zone) ? atk_step : rel_step);
   // fixed rate, so time scales with overshoot
   wire logic signed [31:0] dn_val  = gain_fix - $signed(step);
   wire logic signed [31:0] up_val  = gain_fix + $signed(step);
   wire logic signed [31:0] next_gain = going_down ? ((dn_val < tgt_fix) ? tgt_fix : dn_val) :
                                        ((up_val > tgt_fix) ? tgt_fix : up_val);
   wire logic signed [11:0] gain_int  = 12'((gain_fix + 32'sh00008000) >>> DRC_FRAC);

   // one shared gain, one update per sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_fix <= '0;
      end else if (in_valid) begin
         gain_fix <= act.en ? next_gain : 32'sh0;
      end
   end

   // delay scaled by entry depth at release rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exp_zone_q <= 1'b0;
         delay_acc  <= '0;
         delay_goal <= '0;
         exp_was    <= 1'b0;
      end else if (in_valid) begin
         exp_zone_q <= exp_zone & act.en;
         if (exp_entry) begin
            delay_acc  <= '0;
            delay_goal <= 32'(under) <<< DRC_FRAC;
         end else if (exp_wait) begin
            delay_acc <= delay_acc + $signed(rel_step);
         end
         if (!act.en) begin
            exp_was <= 1'b0;
         end else if (exp_zone && !exp_wait) begin
            exp_was <= 1'b1;
         end else if (!exp_zone && next_gain >= tgt_fix) begin
            exp_was <= 1'b0;
         end
      end
   end

   // bypass path keeps the same one-cycle latency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_frame <= '0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_frame.left  <= act.en ? apply_gain(in_frame.left, gain_int) : in_frame.left;
            out_frame.right <= act.en ? apply_gain(in_frame.right, gain_int) : in_frame.right;
         end
      end
   end

   // flag use outside music filter mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else if (in_valid) begin
         status <= '0;
         status[11:0] <= act.en ? next_gain[27:16] : 12'h000;
         status[DRC_ST_CMP_BIT]  <= act.en & comp_zone;
         status[DRC_ST_EXP_BIT]  <= act.en & exp_zone & ~exp_wait;
         status[DRC_ST_WAIT_BIT] <= act.en & exp_wait;
         status[DRC_ST_MODE_BIT] <= act.en & ~fir_music_mode;
      end
   end

   a_out_latency: assert property (@(posedge pclk) disable iff (!presetn)
      in_valid |=> out_valid)
      else $error("output sample missing one cycle after input");

   a_bypass_data: assert property (@(posedge pclk) disable iff (!presetn)
      (in_valid && !act.en) |=> (out_frame == $past(in_frame)))
      else $error("bypass altered sample");

   a_bypass_gain: assert property (@(posedge pclk) disable iff (!presetn)
      (in_valid && !act.en) |=> (gain_fix == 32'sh0))
      else $error("gain not neutral while bypassed");

   a_cfg_stable: assert property (@(posedge pclk) disable iff (!presetn)
      !in_valid |=> $stable(act))
      else $error("settings changed between samples");

   a_gain_ceiling: assert property (@(posedge pclk) disable iff (!presetn)
      gain_int <= 12'sh00C)
      else $error("gain above +12 dB");

   a_inf_ratio: assert property (@(posedge pclk) disable iff (!presetn)
      (comp_zone && act.cmp == 3'h4) |-> (red_c == comp_over))
      else $error("infinite ratio not flat");

   a_cmp_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      (act.cmp > 3'h4) |-> !comp_zone)
      else $error("reserved ratio code compressing");

   a_step_bound: assert property (@(posedge pclk) disable iff (!presetn)
      (in_valid && act.en) |=> ((gain_fix - $past(gain_fix)) <= $signed($past(step))) &&
                               (($past(gain_fix) - gain_fix) <= $signed($past(step))))
      else $error("gain moved faster than the rate");

   a_exp_delay: assert property (@(posedge pclk) disable iff (!presetn)
      exp_entry |-> (red_e == 12'sh000))
      else $error("expansion applied without delay");

   a_wait_no_drop: assert property (@(posedge pclk) disable iff (!presetn)
      (in_valid && act.en && exp_wait && !comp_zone && gain_fix <= tgt_fix) |=>
      (gain_fix >= $past(gain_fix)))
      else $error("gain dropped during expansion delay");

   a_exp_reduce: assert property (@(posedge pclk) disable iff (!presetn)
      (exp_zone && !exp_wait && !comp_zone) |-> (tgt_db < makeup))
      else $error("expansion zone without gain reduction");

endmodule

// ---- pkg/drc_pkg.sv ----
package drc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  DRC_IDX_TIMING    = 8'h33;
   localparam logic [7:0]  DRC_IDX_COMP      = 8'h34;
   localparam logic [7:0]  DRC_IDX_EXPAND    = 8'h35;
   localparam logic [7:0]  DRC_IDX_MAKEUP    = 8'h36;
   localparam logic [7:0]  DRC_IDX_STATUS    = 8'h3A;
   localparam int          DRC_ADDR_W        = 12;

   // Field positions
   localparam int          DRC_EN_BIT        = 7;
   localparam int          DRC_REL_LSB       = 4;
   localparam int          DRC_ATK_LSB       = 0;
   localparam int          DRC_CMP_LSB       = 5;
   localparam int          DRC_THC_LSB       = 0;
   localparam int          DRC_EXR_LSB       = 5;
   localparam int          DRC_THE_LSB       = 0;
   localparam int          DRC_MKG_LSB       = 0;
   localparam int          DRC_ST_CMP_BIT    = 16;
   localparam int          DRC_ST_EXP_BIT    = 17;
   localparam int          DRC_ST_WAIT_BIT   = 18;
   localparam int          DRC_ST_MODE_BIT   = 19;

   // Reset values
   localparam logic [7:0]  DRC_RST_TIMING    = 8'h00;
   localparam logic [7:0]  DRC_RST_COMP      = 8'h00;
   localparam logic [7:0]  DRC_RST_EXPAND    = 8'h00;
   localparam logic [7:0]  DRC_RST_MAKEUP    = 8'h00;

   // Gain arithmetic
   localparam logic [4:0]  DRC_MAKEUP_MAX    = 5'h0C;
   localparam int          DRC_EXP_THR_BASE  = 35;
   localparam int          DRC_REF_OVER_DB   = 12;
   localparam int          DRC_FRAC          = 16;
   localparam int          DRC_GAIN_FLOOR    = -120;
   localparam int          DRC_SILENCE_DB    = -140;
   localparam int          DRC_US_PER_S      = 1000000;
   localparam int          DRC_SAMPLE_RATE   = 48000;

   // Release and attack times in microseconds, codes 0..7
   localparam int unsigned DRC_RELEASE_US [8] = '{8000000, 4000000, 2000000, 1000000,
                                                  500000, 250000, 125000, 62500};
   localparam int unsigned DRC_ATTACK_US  [8] = '{125, 250, 1250, 2500,
                                                  6250, 12500, 25000, 50000};

   // Attenuation of 0..5 dB in Q1.15
   localparam logic [16:0] DRC_DB_LUT [6] = '{17'h08000, 17'h0721D, 17'h065AD,
                                              17'h05A9E, 17'h050C3, 17'h047FB};
   // Mantissa 1.00/1.25/1.50/1.75 as dB below the next power of two
   localparam logic [3:0]  DRC_MANT_DB [4] = '{4'h6, 4'h4, 4'h2, 4'h1};

   typedef struct packed {
      logic signed [23:0] left;
      logic signed [23:0] right;
   } drc_frame_t;

   typedef struct packed {
      logic       en;
      logic [2:0] rel;
      logic [2:0] atk;
      logic [2:0] cmp;
      logic [4:0] thc;
      logic [2:0] exr;
      logic [4:0] the;
      logic [4:0] mkg;
   } drc_cfg_t;

endpackage

// ---- verif/drc_stream_partner.sv ----
// Upstream equalizer stage as seen by the block: one stereo frame per PERIOD cycles
module drc_stream_partner
   import drc_pkg::*;
#(
   parameter int PERIOD = 4
)(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               run,
   input  wire logic signed [23:0] amp,
   output logic                    in_valid,
   output drc_frame_t              in_frame
);
   timeunit 1ns;
   timeprecision 1ps;

   int cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt      <= 0;
         in_valid <= 1'b0;
         in_frame <= '0;
      end else begin
         in_valid <= 1'b0;
         // Frame only means something in the valid cycle, so scramble it elsewhere
         in_frame <= ~in_frame;
         if (run) begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            if (cnt == 0) begin
               in_valid       <= 1'b1;
               // upstream attenuation keeps frames within full scale
               in_frame.left  <= amp;
               in_frame.right <= -amp;
            end
         end
      end
   end
endmodule

// ---- verif/tb_top.sv ----
`define CHK(g, e) begin \
   checks++; \
   if ((g) !== (e)) begin \
      error_cnt++; \
      $display("mismatch at %0t: got %0h exp %0h", $time, (g), (e)); \
   end \
end

module tb_top
   import drc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic                  pclk;
   logic                  presetn;
   logic                  psel;
   logic                  penable;
   logic                  pwrite;
   logic                  fir_music_mode;
   logic                  run;
   logic [DRC_ADDR_W-1:0] paddr;
   logic [31:0]           pwdata;
   logic [31:0]           prdata;
   logic [31:0]           d;
   logic                  pready;
   logic                  pslverr;
   logic                  err;
   logic                  in_valid;
   logic                  out_valid;
   logic                  iv_q;
   logic signed [23:0]    amp;
   drc_frame_t            in_frame;
   drc_frame_t            out_frame;
   int                    error_cnt;
   int                    checks;

   logic [7:0] idx [4] = '{DRC_IDX_TIMING, DRC_IDX_COMP, DRC_IDX_EXPAND, DRC_IDX_MAKEUP};
   logic [7:0] wv  [4] = '{8'hFF, 8'hFF, 8'hAB, 8'hFF};
   logic [7:0] rv  [4] = '{8'hF7, 8'hFF, 8'hAB, 8'h1F};
   logic [7:0] mk  [4] = '{8'h0C, 8'h06, 8'h0D, 8'h1F};
   int         mf  [4] = '{3981, 1995, 1000, 1000};
   int         cf  [5] = '{1000, 631, 501, 355, 251};

   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   // Slow sample rate so the ramps finish in a few hundred samples
   drc_core #(.SAMPLE_RATE_HZ(1000)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fir_music_mode(fir_music_mode), .in_valid(in_valid), .in_frame(in_frame),
      .out_valid(out_valid), .out_frame(out_frame));

   drc_stream_partner #(.PERIOD(4)) u_src (
      .pclk(pclk), .presetn(presetn), .run(run), .amp(amp),
      .in_valid(in_valid), .in_frame(in_frame));

   always @(posedge pclk) begin
      iv_q <= in_valid & presetn;
      if (presetn) `CHK(out_valid, iv_q)
   end

   task automatic report_and_stop();
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   function automatic logic [DRC_ADDR_W-1:0] ba(logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction

   task automatic apb(input logic [DRC_ADDR_W-1:0] a, input logic w, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         report_and_stop();
      end
      d = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] i, input logic [7:0] v);
      apb(ba(i), 1'b1, {24'h0, v});
   endtask

   task automatic rd(input logic [7:0] i);
      apb(ba(i), 1'b0, 32'h0);
   endtask

   task automatic samples(input int k);
      int n;
      for (int i = 0; i < k; i++) begin
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (out_valid !== 1'b1 && n < 100);
         if (n >= 100) begin
            error_cnt++;
            report_and_stop();
         end
      end
   endtask

   task automatic gain_in(input int lo, input int hi);
      rd(DRC_IDX_STATUS);
      `CHK(($signed(d[11:0]) >= lo) && ($signed(d[11:0]) <= hi), 1'b1)
   endtask

   // Output within pct percent of amp scaled by num/1000
   function automatic logic near(logic signed [23:0] got, int num, int pct);
      logic signed [47:0] e;
      logic signed [47:0] df;
      e = amp;
      e = e * num / 1000;
      df = got - e;
      return (df * 100 <= e * pct) && (-df * 100 <= e * pct);
   endfunction

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      fir_music_mode = 1'b0;
      run = 1'b0;
      amp = '0;
      error_cnt = 0;
      checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(idx[i]);
         `CHK(d, 32'h0)
         wr(idx[i], wv[i]);
         rd(idx[i]);
         `CHK(d, {24'h0, rv[i]})
         wr(idx[i], 8'h00);
      end
      apb(12'h000, 1'b1, 32'hFF);
      `CHK(err, 1'b1)
      apb(ba(DRC_IDX_TIMING) + 12'h1, 1'b0, 32'h0);
      `CHK(err, 1'b1)
      `CHK(d, 32'h0)
      wr(DRC_IDX_STATUS, 8'hFF);
      `CHK(err, 1'b0)
      rd(DRC_IDX_STATUS);
      `CHK(d, 32'h0)
      amp <= 24'sh123456;
      run <= 1'b1;
      samples(3);
      `CHK(out_frame.left, 24'sh123456)
      `CHK(out_frame.right, -24'sh123456)
      wr(DRC_IDX_MAKEUP, 8'h0C);
      wr(DRC_IDX_TIMING, 8'hF0);
      samples(1);
      `CHK(out_frame.left, amp)
      for (int i = 0; i < 4; i++) begin
         wr(DRC_IDX_MAKEUP, mk[i]);
         samples(100);
         `CHK(near(out_frame.left, mf[i], 3), 1'b1)
      end
      wr(DRC_IDX_MAKEUP, 8'h00);
      amp <= 24'sh400000;
      for (int i = 0; i < 5; i++) begin
         wr(DRC_IDX_COMP, {3'(i), 5'd18});
         samples(20);
         `CHK(near(out_frame.left, cf[i], 4), 1'b1)
         `CHK(near(-out_frame.right, cf[i], 4), 1'b1)
      end
      rd(DRC_IDX_STATUS);
      `CHK(d[DRC_ST_CMP_BIT], 1'b1)
      wr(DRC_IDX_COMP, 8'h86);
      samples(3);
      rd(DRC_IDX_STATUS);
      `CHK(d[DRC_ST_CMP_BIT], 1'b0)
      wr(DRC_IDX_COMP, 8'hB2);
      samples(3);
      rd(DRC_IDX_STATUS);
      `CHK(d[DRC_ST_CMP_BIT], 1'b0)
      wr(DRC_IDX_COMP, 8'h12);
      samples(80);
      gain_in(0, 0);
      wr(DRC_IDX_TIMING, 8'hF7);
      wr(DRC_IDX_COMP, 8'h92);
      samples(25);
      gain_in(-8, -4);
      samples(40);
      gain_in(-12, -12);
      amp <= 24'sh080000;
      samples(31);
      gain_in(-8, -4);
      samples(40);
      gain_in(0, 0);
      wr(DRC_IDX_COMP, 8'h12);
      wr(DRC_IDX_TIMING, 8'hF0);
      wr(DRC_IDX_EXPAND, 8'h21);
      amp <= 24'sh008000;
      samples(10);
      rd(DRC_IDX_STATUS);
      `CHK(d[DRC_ST_WAIT_BIT], 1'b1)
      `CHK(d[11:0], 12'h000)
      `CHK(d[DRC_ST_MODE_BIT], 1'b1)
      samples(140);
      gain_in(-13, -11);
      `CHK(d[DRC_ST_EXP_BIT], 1'b1)
      wr(DRC_IDX_EXPAND, 8'h41);
      samples(140);
      gain_in(-25, -23);
      wr(DRC_IDX_EXPAND, 8'h5F);
      samples(3);
      gain_in(0, 0);
      `CHK(d[DRC_ST_EXP_BIT], 1'b0)
      fir_music_mode <= 1'b1;
      samples(2);
      rd(DRC_IDX_STATUS);
      `CHK(d[DRC_ST_MODE_BIT], 1'b0)
      wr(DRC_IDX_TIMING, 8'h00);
      samples(3);
      gain_in(0, 0);
      `CHK(out_frame.left, amp)
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd(DRC_IDX_MAKEUP);
      `CHK(d, 32'h0)
      report_and_stop();
   end
endmodule
